/* File: rtl/tcwo_top.v */
// timer compare and waveform output: counter, compare, flags, pins
// assumes: i_tick is the gated timer clock, one i_clk cycle per tick;
// register port strobes are one cycle and never both at once
//
// Behaviour
// (RULE_01) each channel keeps an output state, zero after reset; setting picks match action
// (RULE_02) nonzero setting drives pin from output state; direction bit stays with port
// (RULE_03) override works in every mode; pin driven only when direction is output
// (RULE_04) setting zero leaves the output state alone at compare match
// (RULE_05) new setting acts at next match; force strobe acts at once outside PWM
// (RULE_06) counting depends on mode bits only, never on the setting
// (RULE_07) mode 0 counts up, wraps 0xFF to 0x00, count writable anytime
// (RULE_08) normal mode sets overflow flag as count becomes zero; hardware only sets
// (RULE_09) mode 2 clears counter when it equals compare register A
// (RULE_10) clear mode has no double buffer; low write runs to 0xFF, wraps
// (RULE_11) clear mode, channel A setting 1 toggles output on every match
// (RULE_12) clear mode sets overflow flag when counter goes from max to 0x00
// (RULE_13) modes 3 and 7 are fast PWM, top 0xFF or compare register A
// (RULE_14) fast PWM: setting 2 clears on match, sets at bottom; 3 inverted
// (RULE_15) fast PWM counts to top, clears next cycle; bottom action then
// (RULE_16) fast PWM sets overflow flag each time counter reaches top
// (RULE_17) fast PWM toggle on channel A only, needs mode bit two set
// (RULE_18) compare A zero gives spike per MAX+1 cycles; max gives steady level
// (RULE_19) fast PWM compare registers double buffered, updated at cycle boundary
// (RULE_20) equal count sets channel compare flag at next tick; writing one clears
`timescale 1ns/1ps
`include "tcwo_consts.vh"

module tcwo_top (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_tick,
  input wire [`TCWO_ADDR_W-1:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rd_data,
  input wire [1:0] i_port_data,
  input wire [1:0] i_port_dir,
  output reg [1:0] o_pin_out,
  output reg [1:0] o_pin_oe,
  output reg o_overflow_flag,
  output reg [1:0] o_compare_flag
);

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  reg [1:0] channel_a_output_setting;
  reg [1:0] channel_b_output_setting;
  reg [2:0] waveform_mode_bits;
  reg [7:0] count_value;
  reg [7:0] compare_buffer_a;
  reg [7:0] compare_buffer_b;
  reg [7:0] compare_register_a;
  reg [7:0] compare_register_b;
  reg match_blocked;

  // ----------------------------------------------------------------
  // decoded strobes
  // ----------------------------------------------------------------
  wire wr_ctrl_a;
  wire wr_ctrl_b;
  wire wr_count;
  wire wr_cmp_a;
  wire wr_cmp_b;
  wire wr_flags;

  assign wr_ctrl_a = i_wr && (i_addr == `TCWO_OFS_CTRL_A);
  assign wr_ctrl_b = i_wr && (i_addr == `TCWO_OFS_CTRL_B);
  assign wr_count = i_wr && (i_addr == `TCWO_OFS_COUNT);
  assign wr_cmp_a = i_wr && (i_addr == `TCWO_OFS_CMP_A);
  assign wr_cmp_b = i_wr && (i_addr == `TCWO_OFS_CMP_B);
  assign wr_flags = i_wr && (i_addr == `TCWO_OFS_FLAGS);

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire mode_clear;
  wire mode_fast;
  wire top_is_cmp;
  wire [7:0] top_value;
  wire at_top;

  // mode bits alone choose the count sequence
  assign mode_clear = (waveform_mode_bits == `TCWO_MODE_CLEAR); // see RULE_06, RULE_09
  assign mode_fast = (waveform_mode_bits == `TCWO_MODE_FAST_MAX) ||
                     (waveform_mode_bits == `TCWO_MODE_FAST_CMP); // see RULE_13
  assign top_is_cmp = mode_clear || (waveform_mode_bits == `TCWO_MODE_FAST_CMP);
  assign top_value = top_is_cmp ? compare_register_a : `TCWO_MAX; // see RULE_13
  assign at_top = (count_value == top_value);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // output settings; the unit applies them at the next match
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      channel_a_output_setting <= `TCWO_RST_SET;
      channel_b_output_setting <= `TCWO_RST_SET;
    end else if (wr_ctrl_a) begin
      channel_a_output_setting <= i_wr_data[`TCWO_CA_SET_A_HI:`TCWO_CA_SET_A_LO];
      channel_b_output_setting <= i_wr_data[`TCWO_CA_SET_B_HI:`TCWO_CA_SET_B_LO];
    end
  end

  // mode bits, spread over both control registers
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      waveform_mode_bits <= `TCWO_RST_MODE;
    end else begin
      if (wr_ctrl_a) begin
        waveform_mode_bits[1:0] <= i_wr_data[`TCWO_CA_WGM_HI:`TCWO_CA_WGM_LO];
      end
      if (wr_ctrl_b) begin
        waveform_mode_bits[2] <= i_wr_data[`TCWO_CB_WGM2];
      end
    end
  end

  // force strobes: ignored in fast PWM
  wire force_a;
  wire force_b;

  assign force_a = wr_ctrl_b && i_wr_data[`TCWO_CB_FORCE_A] && !mode_fast; // see RULE_05
  assign force_b = wr_ctrl_b && i_wr_data[`TCWO_CB_FORCE_B] && !mode_fast; // see RULE_05

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  reg [7:0] next_count;
  wire clear_at_top;

  // clear and fast modes restart at top; the other modes wrap
  assign clear_at_top = (mode_clear || mode_fast) && at_top; // see RULE_06

  // up count, clear at top in clear and fast modes, wrap otherwise
  always @* begin
    next_count = count_value;
    if (i_tick) begin
      if (clear_at_top) begin
        next_count = `TCWO_BOTTOM; // see RULE_09, RULE_15
      end else begin
        next_count = count_value + 8'h01; // see RULE_07, RULE_10
      end
    end
    if (wr_count) begin
      next_count = i_wr_data; // see RULE_07
    end
  end

  // software write beats count and clear
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      count_value <= `TCWO_RST_BYTE;
    end else begin
      count_value <= next_count; // see RULE_07
    end
  end

  // ----------------------------------------------------------------
  // match blocking after a count write
  // ----------------------------------------------------------------
  // held from the write until the next tick, even with the timer stopped
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      match_blocked <= 1'b0;
    end else if (wr_count) begin
      match_blocked <= 1'b1;
    end else if (i_tick) begin
      match_blocked <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // compare registers
  // ----------------------------------------------------------------
  wire cycle_boundary;

  // fast PWM reloads the active compare value as the count clears
  assign cycle_boundary = i_tick && mode_fast && at_top;

  // software side: always the value last written
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      compare_buffer_a <= `TCWO_RST_BYTE;
      compare_buffer_b <= `TCWO_RST_BYTE;
    end else begin
      if (wr_cmp_a) begin
        compare_buffer_a <= i_wr_data;
      end
      if (wr_cmp_b) begin
        compare_buffer_b <= i_wr_data;
      end
    end
  end

  // active values: direct outside PWM, reloaded at the boundary in fast PWM
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      compare_register_a <= `TCWO_RST_BYTE;
      compare_register_b <= `TCWO_RST_BYTE;
    end else if (!mode_fast) begin
      if (wr_cmp_a) begin
        compare_register_a <= i_wr_data; // see RULE_10
      end
      if (wr_cmp_b) begin
        compare_register_b <= i_wr_data;
      end
    end else if (cycle_boundary) begin
      compare_register_a <= compare_buffer_a; // see RULE_19
      compare_register_b <= compare_buffer_b; // see RULE_19
    end
  end

  // ----------------------------------------------------------------
  // per-channel compare, flag and output unit
  // ----------------------------------------------------------------
  wire [15:0] cmp_vec;
  wire [3:0] set_vec;
  wire [1:0] force_vec;
  wire [1:0] match;
  wire [1:0] state;
  wire [1:0] override;
  wire [1:0] cmp_equal;
  wire [1:0] flag_clear;
  wire [1:0] next_compare_flag;
  wire [1:0] next_pin_out;
  wire bottom_evt;

  assign cmp_vec = {compare_register_b, compare_register_a};
  assign set_vec = {channel_b_output_setting, channel_a_output_setting};
  assign force_vec = {force_b, force_a};
  assign bottom_evt = cycle_boundary; // see RULE_15

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      // comparator runs all the time; a match only counts at a tick
      assign cmp_equal[ch] = (count_value == cmp_vec[ch*8 +: 8]);
      // a count write blocks the match of the next tick
      assign match[ch] = i_tick && !match_blocked && cmp_equal[ch]; // see RULE_20
      // any nonzero setting takes the pin from the port
      assign override[ch] = |set_vec[ch*2 +: 2]; // see RULE_02, RULE_03

      tcwo_out_unit #(
        .CHAN_A((ch == 0) ? 1 : 0)
      ) u_out (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_match(match[ch]),
        .i_bottom(bottom_evt),
        .i_force(force_vec[ch]),
        .i_setting(set_vec[ch*2 +: 2]),
        .i_fast(mode_fast),
        .i_wgm2(waveform_mode_bits[2]),
        .o_state(state[ch])
      );

      // flag clear by a written one in the channel's flag bit
      assign flag_clear[ch] = wr_flags && i_wr_data[`TCWO_FL_CMP_A + ch];
      // set wins over a same-cycle clear
      assign next_compare_flag[ch] = match[ch] ||
                                     (o_compare_flag[ch] && !flag_clear[ch]); // see RULE_20

      // pin level from output state or port data
      assign next_pin_out[ch] = override[ch] ? state[ch] : i_port_data[ch]; // see RULE_02
    end
  endgenerate

  // ----------------------------------------------------------------
  // compare flags and pins
  // ----------------------------------------------------------------
  // sticky compare flags, both channels in one register
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_compare_flag <= 2'h0;
    end else begin
      o_compare_flag <= next_compare_flag; // see RULE_20
    end
  end

  // pin level and enable registered together; enable follows direction
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pin_out <= 2'h0;
      o_pin_oe <= 2'h0;
    end else begin
      o_pin_out <= next_pin_out;
      o_pin_oe <= i_port_dir; // see RULE_03
    end
  end

  // ----------------------------------------------------------------
  // overflow flag
  // ----------------------------------------------------------------
  wire count_at_max;
  wire overflow_evt;
  wire ovf_clear;

  // wrap point of normal and clear modes
  assign count_at_max = (count_value == `TCWO_MAX); // see RULE_12
  // normal and clear: max to zero; fast: counter at top
  assign overflow_evt = i_tick && (mode_fast ? at_top : count_at_max)
                        && !wr_count; // see RULE_08, RULE_12, RULE_16
  // software clears with a written one
  assign ovf_clear = wr_flags && i_wr_data[`TCWO_FL_OVF];

  // hardware only sets; set wins over a same-cycle clear
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_overflow_flag <= 1'b0;
    end else if (overflow_evt) begin
      o_overflow_flag <= 1'b1; // see RULE_08
    end else if (ovf_clear) begin
      o_overflow_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  reg [7:0] next_rd_data;

  // read mux; compare reads return the value software wrote
  always @* begin
    next_rd_data = `TCWO_RST_BYTE;
    case (i_addr)
      `TCWO_OFS_CTRL_A: begin
        next_rd_data = {channel_a_output_setting, channel_b_output_setting,
                        2'h0, waveform_mode_bits[1:0]};
      end
      `TCWO_OFS_CTRL_B: next_rd_data = {4'h0, waveform_mode_bits[2], 3'h0};
      `TCWO_OFS_COUNT: next_rd_data = count_value;
      `TCWO_OFS_CMP_A: next_rd_data = compare_buffer_a;
      `TCWO_OFS_CMP_B: next_rd_data = compare_buffer_b;
      `TCWO_OFS_FLAGS: next_rd_data = {5'h00, o_compare_flag, o_overflow_flag};
      default: next_rd_data = `TCWO_RST_BYTE;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= `TCWO_RST_BYTE;
    end else if (i_rd) begin
      o_rd_data <= next_rd_data;
    end else begin
      o_rd_data <= `TCWO_RST_BYTE;
    end
  end

endmodule

/* File: rtl/tcwo_consts.vh */
// constants of the timer compare and waveform output block
// assumes: included by the design files by bare name, definitions only
`ifndef TCWO_CONSTS_VH
`define TCWO_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TCWO_ADDR_W 3
`define TCWO_OFS_CTRL_A 3'h0
`define TCWO_OFS_CTRL_B 3'h1
`define TCWO_OFS_COUNT 3'h2
`define TCWO_OFS_CMP_A 3'h3
`define TCWO_OFS_CMP_B 3'h4
`define TCWO_OFS_FLAGS 3'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCWO_CA_SET_A_HI 7
`define TCWO_CA_SET_A_LO 6
`define TCWO_CA_SET_B_HI 5
`define TCWO_CA_SET_B_LO 4
`define TCWO_CA_WGM_HI 1
`define TCWO_CA_WGM_LO 0
`define TCWO_CB_FORCE_A 7
`define TCWO_CB_FORCE_B 6
`define TCWO_CB_WGM2 3
`define TCWO_FL_OVF 0
`define TCWO_FL_CMP_A 1
`define TCWO_FL_CMP_B 2

// ----------------------------------------------------------------
// reset values, count limits, mode and setting codes
// ----------------------------------------------------------------
`define TCWO_RST_BYTE 8'h00
`define TCWO_RST_SET 2'h0
`define TCWO_RST_MODE 3'h0
`define TCWO_RST_STATE 1'h0
`define TCWO_BOTTOM 8'h00
`define TCWO_MAX 8'hFF
`define TCWO_MODE_NORMAL 3'h0
`define TCWO_MODE_CLEAR 3'h2
`define TCWO_MODE_FAST_MAX 3'h3
`define TCWO_MODE_FAST_CMP 3'h7
`define TCWO_SET_OFF 2'h0
`define TCWO_SET_TOGGLE 2'h1
`define TCWO_SET_CLEAR 2'h2
`define TCWO_SET_SET 2'h3

`endif

/* File: rtl/tcwo_out_unit.v */
// one channel of the compare output unit: the internal output state
// assumes: match, bottom and force are one-cycle pulses in i_clk
`timescale 1ns/1ps
`include "tcwo_consts.vh"

module tcwo_out_unit #(
  parameter CHAN_A = 1
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_match,
  input wire i_bottom,
  input wire i_force,
  input wire [1:0] i_setting,
  input wire i_fast,
  input wire i_wgm2,
  output reg o_state
);

  // ----------------------------------------------------------------
  // next state of the output
  // ----------------------------------------------------------------
  reg next_state;

  // action chosen by the setting at match, force or bottom
  always @* begin
    next_state = o_state;
    if (i_fast) begin
      if (i_match) begin
        case (i_setting)
          `TCWO_SET_TOGGLE: begin
            if (CHAN_A != 0 && i_wgm2) begin // see RULE_17
              next_state = ~o_state;
            end
          end
          `TCWO_SET_CLEAR: next_state = 1'b0; // see RULE_14
          `TCWO_SET_SET: next_state = 1'b1; // see RULE_14
          default: next_state = o_state; // see RULE_04
        endcase
      end
      // bottom wins over a same-cycle match: steady level at max
      if (i_bottom) begin
        case (i_setting)
          `TCWO_SET_CLEAR: next_state = 1'b1; // see RULE_15, RULE_18
          `TCWO_SET_SET: next_state = 1'b0; // see RULE_15, RULE_18
          default: next_state = next_state;
        endcase
      end
    end else if (i_match || i_force) begin // see RULE_05
      case (i_setting)
        `TCWO_SET_TOGGLE: next_state = ~o_state; // see RULE_11
        `TCWO_SET_CLEAR: next_state = 1'b0;
        `TCWO_SET_SET: next_state = 1'b1;
        default: next_state = o_state; // see RULE_04
      endcase
    end
  end

  // state register, cleared by system reset
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_state <= `TCWO_RST_STATE; // see RULE_01
    end else begin
      o_state <= next_state;
    end
  end

endmodule

/* File: bench/tcwo_chk.sv */
// assertions on the ports of the timer compare and waveform output block
// assumes: bound to tcwo_top, one clock domain, synchronous active-high reset
`timescale 1ns/1ps
`include "tcwo_consts.vh"

module tcwo_chk (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_tick,
  input wire [`TCWO_ADDR_W-1:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rd_data,
  input wire [1:0] i_port_data,
  input wire [1:0] i_port_dir,
  input wire [1:0] o_pin_out,
  input wire [1:0] o_pin_oe,
  input wire o_overflow_flag,
  input wire [1:0] o_compare_flag
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // ----------------------------------------------------------------
  // pins and flags
  // ----------------------------------------------------------------
  AST_OE_DIR: assert property (!$past(i_sys_rst) |-> o_pin_oe == $past(i_port_dir))
    else $error("pin enable does not follow direction bits");
  AST_PIN_CAUSE: assert property ($changed(o_pin_out) |-> $past(i_tick, 2) || $past(i_wr, 2)
    || $past(i_sys_rst, 2) || ($past(i_port_data) != $past(i_port_data, 2)))
    else $error("pin changed without tick, write or port data change");
  AST_OVF_HOLD: assert property ($past(o_overflow_flag) && !($past(i_wr)
    && $past(i_addr) == `TCWO_OFS_FLAGS && $past(i_wr_data[0])) |-> o_overflow_flag)
    else $error("overflow flag dropped without software clear");
  AST_OVF_CLR: assert property ($past(i_wr) && $past(i_addr) == `TCWO_OFS_FLAGS
    && $past(i_wr_data[0]) && !$past(i_tick) |-> !o_overflow_flag)
    else $error("overflow flag not cleared by write of one");
  AST_OVF_TICK: assert property ($rose(o_overflow_flag) |-> $past(i_tick))
    else $error("overflow flag rose without a timer tick");
  AST_CMPA_TICK: assert property ($rose(o_compare_flag[0]) |-> $past(i_tick))
    else $error("compare flag A rose without a timer tick");
  AST_CMPB_HOLD: assert property ($past(o_compare_flag[1]) && !($past(i_wr)
    && $past(i_addr) == `TCWO_OFS_FLAGS && $past(i_wr_data[2])) |-> o_compare_flag[1])
    else $error("compare flag B dropped without software clear");
  AST_CMPA_CLR: assert property ($past(i_wr) && $past(i_addr) == `TCWO_OFS_FLAGS
    && $past(i_wr_data[1]) && !$past(i_tick) |-> !o_compare_flag[0])
    else $error("compare flag A not cleared by write of one");
endmodule

bind tcwo_top tcwo_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tick(i_tick),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
  .i_port_data(i_port_data), .i_port_dir(i_port_dir), .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe), .o_overflow_flag(o_overflow_flag), .o_compare_flag(o_compare_flag));

/* File: bench/tcwo_tb_top.sv */
// testbench of the timer compare and waveform output block
// assumes: tcwo_top and its checker are compiled before this file
`timescale 1ns/1ps
`include "tcwo_consts.vh"

module tcwo_tb_top;
  logic i_clk;
  logic i_sys_rst;
  logic i_tick;
  logic [`TCWO_ADDR_W-1:0] i_addr;
  logic [7:0] i_wr_data;
  logic i_wr;
  logic i_rd;
  logic [1:0] i_port_data;
  logic [1:0] i_port_dir;
  wire [7:0] o_rd_data;
  wire [1:0] o_pin_out;
  wire [1:0] o_pin_oe;
  wire o_overflow_flag;
  wire [1:0] o_compare_flag;
  int n_errors;
  int checks;
  logic [1:0] set_tab [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  logic [3:0] exp_bits = 4'b0101;

  tcwo_top dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_tick(i_tick), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .i_port_data(i_port_data), .i_port_dir(i_port_dir), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_overflow_flag(o_overflow_flag), .o_compare_flag(o_compare_flag));

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    results();
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [`TCWO_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [`TCWO_ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rd_data, exp);
  endtask
  // n back-to-back timer ticks
  task automatic run(input int n);
    @(posedge i_clk);
    i_tick <= 1'b1;
    repeat (n) @(posedge i_clk);
    i_tick <= 1'b0;
  endtask
  // pins lag the output state by one edge
  task automatic pin(input logic [1:0] exp);
    @(posedge i_clk);
    #1 chk({6'h00, o_pin_out}, {6'h00, exp});
  endtask
  task automatic flg(input logic [2:0] exp);
    #1 chk({5'h00, o_compare_flag, o_overflow_flag}, {5'h00, exp});
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    i_sys_rst = 1'b1;
    i_tick = 1'b0;
    i_addr = '0;
    i_wr_data = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_port_data = 2'b00;
    i_port_dir = 2'b00;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    // reset values, unmapped read, port pass-through
    rd(`TCWO_OFS_CTRL_A, 8'h00);
    rd(`TCWO_OFS_COUNT, 8'h00);
    rd(3'h6, 8'h00);
    @(posedge i_clk);
    i_port_dir <= 2'b11;
    i_port_data <= 2'b10;
    pin(2'b10);
    chk({6'h00, o_pin_oe}, 8'h03);
    @(posedge i_clk);
    i_port_data <= 2'b00;
    $display("test reset done");
    // normal mode wrap and overflow
    wr(`TCWO_OFS_COUNT, 8'hFD);
    run(2);
    flg(3'b000);
    run(1);
    flg(3'b001);
    rd(`TCWO_OFS_COUNT, 8'h00);
    wr(`TCWO_OFS_FLAGS, 8'h07);
    flg(3'b000);
    $display("test normal done");
    // clear-on-match with toggle on A, B left alone
    wr(`TCWO_OFS_CMP_A, 8'h02);
    wr(`TCWO_OFS_CTRL_A, 8'h42);
    run(3);
    flg(3'b110);
    pin(2'b01);
    rd(`TCWO_OFS_COUNT, 8'h00);
    run(3);
    pin(2'b00);
    wr(`TCWO_OFS_FLAGS, 8'h07);
    wr(`TCWO_OFS_COUNT, 8'h05);
    run(250);
    flg(3'b000);
    run(1);
    flg(3'b001);
    rd(`TCWO_OFS_COUNT, 8'h00);
    $display("test clear done");
    // forced actions for settings 3, 2 and 1 (set, clear, toggle twice) in normal mode
    wr(`TCWO_OFS_FLAGS, 8'h07);
    wr(`TCWO_OFS_CTRL_A, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(`TCWO_OFS_CTRL_A, {set_tab[i], 6'h00});
      wr(`TCWO_OFS_CTRL_B, 8'h80);
      pin({1'b0, exp_bits[i]});
    end
    flg(3'b000);
    $display("test force done");
    // fast PWM with top from compare A
    wr(`TCWO_OFS_COUNT, 8'h00);
    wr(`TCWO_OFS_CMP_A, 8'h04);
    wr(`TCWO_OFS_CMP_B, 8'h02);
    wr(`TCWO_OFS_CTRL_B, 8'h08);
    wr(`TCWO_OFS_CTRL_A, 8'hB3);
    wr(`TCWO_OFS_FLAGS, 8'h07);
    run(3);
    pin(2'b10);
    run(2);
    pin(2'b01);
    flg(3'b111);
    rd(`TCWO_OFS_COUNT, 8'h00);
    wr(`TCWO_OFS_CMP_B, 8'h01);
    rd(`TCWO_OFS_CMP_B, 8'h01);
    run(2);
    pin(2'b01);
    run(1);
    pin(2'b11);
    run(4);
    pin(2'b11);
    wr(`TCWO_OFS_CTRL_B, 8'h88);
    pin(2'b11);
    $display("test fast done");
    // toggle on A only with mode bit two set
    wr(`TCWO_OFS_CTRL_A, 8'h73);
    run(3);
    run(1);
    pin(2'b00);
    wr(`TCWO_OFS_CTRL_B, 8'h00);
    run(5);
    pin(2'b10);
    $display("test toggle done");
    // extreme compare values in fast PWM with top at max, A non-inverted
    wr(`TCWO_OFS_CMP_A, 8'hFF);
    wr(`TCWO_OFS_CTRL_A, 8'h83);
    run(250);
    run(256);
    pin(2'b01);
    wr(`TCWO_OFS_CMP_A, 8'h00);
    run(256);
    pin(2'b01);
    run(1);
    pin(2'b00);
    $display("test extreme done");
    results();
  end
endmodule
